// [hdl/plc_params.svh]
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// Register offsets
`define PLC_ADDR_LED_COMMON  8'h78
`define PLC_ADDR_LED0_REF    8'h79
`define PLC_ADDR_LED0_CTL    8'h7A
`define PLC_ADDR_LED1_CTL    8'h7B
`define PLC_ADDR_LED2_CTL    8'h7C
`define PLC_ADDR_PFAIL       8'h7D
`define PLC_ADDR_BOOT_CFG    8'h7E
`define PLC_ADDR_STAY_ON     8'h7F
`define PLC_ADDR_PWR_CMD     8'h80
`define PLC_ADDR_BUCK_CFG    8'h81
`define PLC_ADDR_LOCK_MASK   8'h83
`define PLC_ADDR_LOCK_PASS   8'h84

// Power command codes
`define PLC_CMD_OFF          8'hB2
`define PLC_CMD_HARD_RESET   8'hC3
`define PLC_CMD_SOFT_RESET   8'hD4
`define PLC_CMD_SEAL         8'hE5
`define PLC_CMD_BATT_RECOV   8'hF6

// Lock password codes
`define PLC_PASS_UNLOCK      8'h55
`define PLC_PASS_LOCK        8'hAA

// Seal allowed configurations
`define PLC_SEAL_CFG_A       4'hB
`define PLC_SEAL_CFG_B       4'hC

// Reset values
`define PLC_RST_LED_CTL      8'h00
`define PLC_RST_LED_REF      2'h0
`define PLC_RST_BUCK_CFG     8'h00
`define PLC_RST_LOCK_MASK    8'h00
`define PLC_RST_LOCK_STATE   8'h00

// Stay-on window: 5 s at 40 MHz
`define PLC_STAY_ON_S        5
`define PLC_CLK_HZ           40000000
`define PLC_STAY_ON_CYCLES   (`PLC_STAY_ON_S * `PLC_CLK_HZ)

// Boost loop increment limit in mV
`define PLC_BOOST_MAX_MV     5000

`endif

// [hdl/plc_pkg.sv]
package plc_pkg;

	typedef enum logic [1:0] {
		PLC_STEP_0P6,
		PLC_STEP_1P0,
		PLC_STEP_1P2,
		PLC_STEP_RSVD
	} plc_step_t;

	typedef struct packed {
		logic [2:0] enable_select;
		logic [4:0] current_code;
	} plc_led_ctl_t;

	typedef struct packed {
		logic [1:0] forced_dcm;
		logic [2:0] dvs_valley;
		logic [2:0] low_bandwidth;
	} plc_buck_t;

	typedef struct packed {
		logic       valid;
		logic       off_mode;
		logic       hard_reset;
		logic       soft_reset;
		logic       seal_mode;
		logic       batt_recovery;
	} plc_cmd_t;

	typedef enum logic [1:0] {
		PLC_ST_WAIT,
		PLC_ST_CONFIRMED,
		PLC_ST_EXPIRED
	} plc_stay_t;

	typedef struct packed {
		logic [2:0]   rst_sync;
		plc_led_ctl_t [2:0] led;
		logic [1:0]   led_ref;
		logic         boost_loop;
		plc_step_t    step;
		plc_buck_t    buck;
		logic [7:0]   lock_mask;
		logic [7:0]   lock_state;
		logic [7:0]   cmd_reg;
		plc_stay_t    stay;
		logic         stay_on;
		logic [27:0]  stay_cnt;
		logic         shutdown;
		plc_cmd_t     cmd;
		logic [2:0]   led_on;
		logic [1:0]   dropout_ref;
		logic [7:0]   rdata;
		logic [1:0]   pf_s1;
		logic [1:0]   pf_s2;
		logic [4:0]   mpc_s1;
		logic [4:0]   mpc_s2;
		logic         chg_s1;
		logic         chg_s2;
	} plc_state_t;

endpackage

// [hdl/plc_regs.sv]
`timescale 1ns/1ps
`include "plc_params.svh"
module plc_regs
	import plc_pkg::*;
#(
	parameter int unsigned STAY_ON_CYCLES = `PLC_STAY_ON_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Register port from the serial slave
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Pins and internal status
	input  wire logic [1:0] power_fail_in,
	input  wire logic [4:0] multipurpose_pin,
	input  wire logic       charger_status,
	input  wire logic [3:0] power_reset_config,
	input  wire logic       soft_reset_policy,
	input  wire logic [1:0] boot_delay_select,
	input  wire logic       uvlo_retry_select,
	input  wire logic       harvester_enable,
	// Analog controls
	output logic [2:0]      led_sink_on,
	output plc_led_ctl_t [2:0] led_ctl,
	output plc_step_t       led_current_step,
	output logic            boost_closed_loop_enable,
	output logic [1:0]      led0_dropout_select,
	output plc_buck_t       buck_cfg,
	output logic [7:0]      lock_state,
	// Power commands, one-cycle pulses
	output plc_cmd_t        power_cmd,
	output logic            stay_on_shutdown
);

	plc_state_t s_q;
	plc_state_t s_d;
	logic       rst_n;
	logic       wr_cmd;

	assign rst_n = s_q.rst_sync[1];

	always_comb begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[1:0], 1'b1};
		// Pin synchronisers
		s_d.pf_s1  = power_fail_in;
		s_d.pf_s2  = s_q.pf_s1;
		s_d.mpc_s1 = multipurpose_pin;
		s_d.mpc_s2 = s_q.mpc_s1;
		s_d.chg_s1 = charger_status;
		s_d.chg_s2 = s_q.chg_s1;
		s_d.cmd    = '0;
		wr_cmd = 1'b0;

		if (reg_wr) begin
			unique case (reg_addr)
				`PLC_ADDR_LED_COMMON: begin
					s_d.boost_loop = reg_wdata[7];
					s_d.step       = plc_step_t'(reg_wdata[1:0]);
				end
				`PLC_ADDR_LED0_REF:  s_d.led_ref = reg_wdata[1:0];
				`PLC_ADDR_LED0_CTL:  s_d.led[0]  = reg_wdata;
				`PLC_ADDR_LED1_CTL:  s_d.led[1]  = reg_wdata;
				`PLC_ADDR_LED2_CTL:  s_d.led[2]  = reg_wdata;
				`PLC_ADDR_STAY_ON: begin
					if (s_q.stay == PLC_ST_WAIT && reg_wdata[0]) begin
						s_d.stay_on = 1'b1;
						s_d.stay    = PLC_ST_CONFIRMED;
					end
				end
				`PLC_ADDR_PWR_CMD: begin
					s_d.cmd_reg = reg_wdata;
					wr_cmd      = 1'b1;
				end
				`PLC_ADDR_BUCK_CFG:  s_d.buck      = reg_wdata;
				`PLC_ADDR_LOCK_MASK: s_d.lock_mask = reg_wdata;
				`PLC_ADDR_LOCK_PASS: begin
					if (reg_wdata == `PLC_PASS_UNLOCK) begin
						s_d.lock_state = s_q.lock_state & s_q.lock_mask;
					end else if (reg_wdata == `PLC_PASS_LOCK) begin
						s_d.lock_state = s_q.lock_state | ~s_q.lock_mask;
					end
				end
				default: ;
			endcase
		end

		// Command decode one cycle after the write, then self-clear
		if (s_q.cmd_reg != 8'h00) begin
			unique case (s_q.cmd_reg)
				`PLC_CMD_OFF:        s_d.cmd.off_mode   = 1'b1;
				`PLC_CMD_HARD_RESET: s_d.cmd.hard_reset = 1'b1;
				`PLC_CMD_SOFT_RESET: s_d.cmd.soft_reset = 1'b1;
				`PLC_CMD_SEAL: begin
					s_d.cmd.seal_mode = (power_reset_config == `PLC_SEAL_CFG_A) ||
						(power_reset_config == `PLC_SEAL_CFG_B);
				end
				`PLC_CMD_BATT_RECOV: s_d.cmd.batt_recovery = harvester_enable;
				default: ;
			endcase
			if (!wr_cmd) begin
				s_d.cmd_reg = 8'h00;
			end
		end
		s_d.cmd.valid = s_d.cmd.off_mode | s_d.cmd.hard_reset | s_d.cmd.soft_reset |
			s_d.cmd.seal_mode | s_d.cmd.batt_recovery;

		// Stay-on watchdog
		s_d.shutdown = 1'b0;
		if (s_q.stay == PLC_ST_WAIT && s_d.stay == PLC_ST_WAIT) begin
			if (s_q.stay_cnt >= 28'(STAY_ON_CYCLES - 1)) begin
				s_d.stay     = PLC_ST_EXPIRED;
				s_d.shutdown = 1'b1;
			end else begin
				s_d.stay_cnt = s_q.stay_cnt + 28'h0000001;
			end
		end

		// LED enable decode
		for (int i = 0; i < 3; i++) begin
			unique case (s_q.led[i].enable_select)
				3'h0:    s_d.led_on[i] = 1'b0;
				3'h1:    s_d.led_on[i] = 1'b1;
				3'h2:    s_d.led_on[i] = s_q.chg_s2;
				default: s_d.led_on[i] = s_q.mpc_s2[s_q.led[i].enable_select - 3'h3];
			endcase
		end
		// Dropout reference follows the loop bit in the same cycle, no stale value
		s_d.dropout_ref = s_d.boost_loop ? s_d.led_ref : 2'h0;

		// Read data
		s_d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`PLC_ADDR_LED_COMMON: s_d.rdata = {s_q.boost_loop, 5'h00, s_q.step};
				`PLC_ADDR_LED0_REF:   s_d.rdata = {6'h00, s_q.led_ref};
				`PLC_ADDR_LED0_CTL:   s_d.rdata = s_q.led[0];
				`PLC_ADDR_LED1_CTL:   s_d.rdata = s_q.led[1];
				`PLC_ADDR_LED2_CTL:   s_d.rdata = s_q.led[2];
				`PLC_ADDR_PFAIL:      s_d.rdata = {6'h00, s_q.pf_s2};
				`PLC_ADDR_BOOT_CFG:   s_d.rdata = {power_reset_config, soft_reset_policy,
					boot_delay_select, uvlo_retry_select};
				`PLC_ADDR_STAY_ON:    s_d.rdata = {7'h00, s_q.stay_on};
				`PLC_ADDR_PWR_CMD:    s_d.rdata = s_q.cmd_reg;
				`PLC_ADDR_BUCK_CFG:   s_d.rdata = s_q.buck;
				`PLC_ADDR_LOCK_MASK:  s_d.rdata = s_q.lock_mask;
				`PLC_ADDR_LOCK_PASS:  s_d.rdata = s_q.lock_state;
				default:              s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q          <= '0;
			s_q.step     <= PLC_STEP_0P6;
			s_q.stay     <= PLC_ST_WAIT;
			s_q.buck     <= `PLC_RST_BUCK_CFG;
			s_q.lock_mask <= `PLC_RST_LOCK_MASK;
		end else if (!rst_n) begin
			s_q          <= '0;
			s_q.rst_sync <= s_d.rst_sync;
			s_q.stay     <= PLC_ST_WAIT;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata                = s_q.rdata;
	assign led_sink_on              = s_q.led_on;
	assign led_ctl                  = s_q.led;
	assign led_current_step         = s_q.step;
	assign boost_closed_loop_enable = s_q.boost_loop;
	assign led0_dropout_select      = s_q.dropout_ref;
	assign buck_cfg                 = s_q.buck;
	assign lock_state               = s_q.lock_state;
	assign power_cmd                = s_q.cmd;
	assign stay_on_shutdown         = s_q.shutdown;

endmodule

// [testbench/plc_host.sv]
`timescale 1ns/1ps
module plc_host (
	// Clock and read return
	input wire logic [7:0] reg_rdata,
	input wire logic       clk,
	// Requests
	output logic           reg_wr,
	output logic           reg_rd,
	output logic [7:0]     reg_addr,
	output logic [7:0]     reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Idle address and data lines invert and both strobes drop low, so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge clk);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// [testbench/plc_regs_chk.sv]
`timescale 1ns/1ps
module plc_regs_chk
	import plc_pkg::*;
(
	// Clock, reset, register port
	input wire logic               clk,
	input wire logic               resetn,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [7:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic [7:0]         reg_rdata,
	// Pins and controls
	input wire logic [1:0]         power_fail_in,
	input wire logic [3:0]         power_reset_config,
	input wire logic               harvester_enable,
	input wire logic [2:0]         led_sink_on,
	input wire plc_led_ctl_t [2:0] led_ctl,
	input wire logic               boost_closed_loop_enable,
	input wire logic [1:0]         led0_dropout_select,
	input wire plc_cmd_t           power_cmd
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic cw;
	logic known;
	logic sealok;
	assign cw = reg_wr && reg_addr == 8'h80;
	assign known = reg_wdata inside {8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
	assign sealok = power_reset_config inside {4'hB, 4'hC};
	sequence pf_rd;
		$stable(power_fail_in)[*4] ##0 reg_rd && reg_addr == 8'h7D;
	endsequence
	sequence led_hold;
		(led_ctl[0].enable_select inside {3'h0, 3'h1} && $stable(led_ctl[0]))[*2];
	endsequence
	chk_off_pulse: assert property (cw && reg_wdata == 8'hB2 |-> ##2 power_cmd.off_mode)
		else $error("off pulse missing");
	chk_bad_code: assert property (cw && !known |-> ##2 !power_cmd.valid)
		else $error("unknown code pulsed");
	chk_seal_gate: assert property (cw && reg_wdata == 8'hE5 && !sealok |-> ##2 !power_cmd.seal_mode)
		else $error("seal not gated");
	chk_recov_gate: assert property (cw && reg_wdata == 8'hF6 && !harvester_enable |-> ##2 power_cmd == 6'h00)
		else $error("recovery not gated");
	chk_cmd_onehot: assert property (power_cmd.valid == (|power_cmd[4:0]) && $onehot0(power_cmd[4:0]))
		else $error("command pulse malformed");
	chk_dropout_gate: assert property (!boost_closed_loop_enable |-> led0_dropout_select == 2'h0)
		else $error("dropout select without loop");
	chk_pfail_read: assert property (pf_rd |=> reg_rdata == {6'h00, $past(power_fail_in)})
		else $error("power fail status wrong");
	chk_led_follow: assert property (led_hold |-> led_sink_on[0] == led_ctl[0].enable_select[0])
		else $error("sink enable wrong");
endmodule
bind plc_regs plc_regs_chk plc_regs_chk_i (.*);

// [testbench/plc_regs_test.sv]
`timescale 1ns/1ps
module plc_regs_test
	import plc_pkg::*;
();
	localparam int STAY = 400;
	logic clk, resetn, reg_wr, reg_rd, charger_status, harvester_enable, stay_on_shutdown;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, boot, buck_cfg, lock_state;
	logic [1:0] power_fail_in, led0_dropout_select;
	logic [4:0] multipurpose_pin;
	logic [2:0] led_sink_on;
	logic boost_closed_loop_enable;
	plc_led_ctl_t [2:0] led_ctl;
	plc_step_t led_current_step;
	plc_cmd_t power_cmd;
	int errors, check_count, cyc, shut_at;

	plc_host plc_host_i (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	plc_regs #(.STAY_ON_CYCLES(STAY)) plc_regs_i (.clk(clk), .resetn(resetn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .power_fail_in(power_fail_in),
		.multipurpose_pin(multipurpose_pin), .charger_status(charger_status),
		.power_reset_config(boot[7:4]), .soft_reset_policy(boot[3]),
		.boot_delay_select(boot[2:1]), .uvlo_retry_select(boot[0]),
		.harvester_enable(harvester_enable), .led_sink_on(led_sink_on), .led_ctl(led_ctl),
		.led_current_step(led_current_step), .boost_closed_loop_enable(boost_closed_loop_enable),
		.led0_dropout_select(led0_dropout_select), .buck_cfg(buck_cfg),
		.lock_state(lock_state), .power_cmd(power_cmd), .stay_on_shutdown(stay_on_shutdown));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= resetn ? cyc + 1 : 0;
		if (!resetn) shut_at <= -1;
		else if (stay_on_shutdown) shut_at <= cyc;
	end

	task automatic chk(input string n, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		plc_host_i.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, e);
		logic [7:0] q;
		plc_host_i.xfer(1'b0, a, 8'h00, q);
		chk("rdata", e, q);
	endtask
	task automatic do_reset;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [5:0] e);
		wr(8'h80, c);
		@(posedge clk);
		#1 chk("power_cmd", 8'(e), 8'(power_cmd));
		rd(8'h80, 8'h00);
	endtask
	task automatic t_led;
		logic [7:0] lvl;
		lvl = {multipurpose_pin, charger_status, 2'b10};
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 8; c++) begin
				wr(8'(8'h7A + i), {3'(c), 5'h18});
				repeat (4) @(posedge clk);
				#1 chk("sink_on", 8'(lvl[c]), 8'(led_sink_on[i]));
				chk("led_ctl", {3'(c), 5'h18}, led_ctl[i]);
			end
		end
	endtask

	initial begin
		resetn = 1'b0;
		power_fail_in = 2'b00;
		multipurpose_pin = 5'h16;
		charger_status = 1'b1;
		boot = 8'hBD;
		harvester_enable = 1'b1;
		do_reset;
		wr(8'h7F, 8'h01);
		t_led;
		wr(8'h79, 8'hFF);
		rd(8'h79, 8'h03);
		chk("dropout", 8'h00, 8'(led0_dropout_select));
		for (int s = 0; s < 3; s++) begin
			wr(8'h78, 8'(8'h80 + s));
			chk("step", 8'(s), 8'(led_current_step));
		end
		chk("dropout", 8'h03, 8'(led0_dropout_select));
		chk("boost_loop", 8'h01, 8'(boost_closed_loop_enable));
		wr(8'h78, 8'h00);
		chk("boost_loop", 8'h00, 8'(boost_closed_loop_enable));
		chk("dropout", 8'h00, 8'(led0_dropout_select));
		wr(8'h78, 8'h82);
		power_fail_in = 2'b10;
		repeat (4) @(posedge clk);
		rd(8'h7D, 8'h02);
		wr(8'h7E, 8'h00);
		rd(8'h7E, boot);
		rd(8'h82, 8'h00);
		cmd(8'hB2, 6'h30);
		cmd(8'hC3, 6'h28);
		cmd(8'hD4, 6'h24);
		cmd(8'hE5, 6'h22);
		cmd(8'hF6, 6'h21);
		cmd(8'h5A, 6'h00);
		boot[7:4] = 4'hC;
		cmd(8'hE5, 6'h22);
		boot[7:4] = 4'hA;
		cmd(8'hE5, 6'h00);
		harvester_enable = 1'b0;
		cmd(8'hF6, 6'h00);
		wr(8'h81, 8'hA5);
		chk("buck", 8'hA5, buck_cfg);
		rd(8'h81, 8'hA5);
		wr(8'h83, 8'h0F);
		wr(8'h84, 8'hAA);
		chk("lock", 8'hF0, lock_state);
		wr(8'h84, 8'h12);
		wr(8'h83, 8'hF0);
		wr(8'h84, 8'h55);
		rd(8'h84, 8'hF0);
		wr(8'h83, 8'h00);
		wr(8'h84, 8'h55);
		rd(8'h84, 8'h00);
		wr(8'h7F, 8'h00);
		repeat (STAY) @(posedge clk);
		chk("kept_on", 8'h01, 8'(shut_at < 0));
		#1;
		do_reset;
		repeat (STAY + 50) @(posedge clk);
		chk("shut_time", 8'h01, 8'(shut_at inside {[STAY - 4:STAY + 4]}));
		wr(8'h7F, 8'h01);
		rd(8'h7F, 8'h00);
		wrap_up;
	end

	task automatic wrap_up;
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
endmodule
